// *** src/nbp_pkg.sv ***
// Purpose: shared constants and carriers for the nibble port bank
// Assumes: banked data memory port access, 4-bit data
// Notes: offsets are data-memory addresses within a bank
package nbp_pkg;
   // ****************************************
   // address map
   // ****************************************
   localparam logic [1:0] BANK_0 = 2'h0;
   localparam logic [1:0] BANK_1 = 2'h1;
   localparam logic [1:0] BANK_2 = 2'h2;
   localparam logic [6:0] OFS_PORT_2D = 7'h6f;
   localparam logic [6:0] OFS_PORT_X0 = 7'h70;
   localparam logic [6:0] OFS_PORT_X1 = 7'h71;
   localparam logic [6:0] OFS_PORT_X2 = 7'h72;
   localparam logic [6:0] OFS_PORT_X3 = 7'h73;
   // ****************************************
   // field values
   // ****************************************
   localparam logic [3:0] NIB_ZERO = 4'h0;
   localparam logic [3:0] NIB_ONES = 4'hf;
   localparam logic [3:0] MASK_2D = 4'h7;
   localparam logic [3:0] MASK_2A = 4'h1;
   localparam logic [3:0] MASK_RMW = 4'h3;
   localparam int NPORT_BIDIR = 5;
   // ****************************************
   // carriers
   // ****************************************
   typedef struct packed {
      logic [1:0] bank;
      logic [6:0] addr;
      logic [3:0] wdata;
      logic wr;
      logic rd;
      logic rmw;
   } nbp_access_t;
   typedef struct packed {
      logic [3:0] first;
      logic [3:0] second;
      logic [3:0] third;
      logic nibble;
      logic [3:0] fourth;
   } nbp_dir_t;
endpackage : nbp_pkg

// *** src/nbp_port_bank.sv ***
// Purpose: 4-bit general-purpose port bank behind banked data memory
// Assumes: one cpu clock, pins sampled through three flops
// Notes: pin levels seen by reads lag the pins by the sync delay
//
// Functional notes
// - bit ports per pin, nibble port all four
// - direction from each port's select register
// - input mode releases driver; open-drain 1 also floats
// - input mode read returns pin level
// - input mode write updates latch only
// - output mode drives latch value
// - output mode read returns latch
// - first port bits 0,1 read pin level
// - rmw rewrites first port bits 0,1 latch
// - power-on: inputs, bidir latches cleared
// - ce reset, clock stop: inputs, latches kept
// - halt freezes latches; direction and pins too, unless ce reset or clock stop
// - input port reads pins, ignores writes
// - input port pulled down, always input
// - push-pull outputs drive latch, read latch
// - open-drain: low for 0, float for 1
// - output latches undefined until software writes
// - output latches survive ce reset, clock stop
`timescale 1ns/1ps
module nbp_port_bank (
   // clock and resets
   input wire logic clock_in,
   input wire logic reset_n_in,
   input wire logic ce_reset_in,
   input wire logic clock_stop_in,
   input wire logic halt_in,
   // cpu data memory access
   input wire nbp_pkg::nbp_access_t access_in,
   output logic [3:0] rdata_out,
   // direction select registers
   input wire logic dir_we_in,
   input wire nbp_pkg::nbp_dir_t dir_in,
   output nbp_pkg::nbp_dir_t dir_out,
   // bidirectional pins
   input wire logic [3:0] first_bidir_port_in,
   output logic [3:0] first_bidir_port_out,
   output logic [3:0] first_bidir_port_oe_out,
   input wire logic [3:0] second_bidir_port_in,
   output logic [3:0] second_bidir_port_out,
   output logic [3:0] second_bidir_port_oe_out,
   input wire logic [3:0] third_bidir_port_in,
   output logic [3:0] third_bidir_port_out,
   output logic [3:0] third_bidir_port_oe_out,
   input wire logic [3:0] nibble_bidir_port_in,
   output logic [3:0] nibble_bidir_port_out,
   output logic [3:0] nibble_bidir_port_oe_out,
   input wire logic [3:0] fourth_bidir_port_in,
   output logic [3:0] fourth_bidir_port_out,
   output logic [3:0] fourth_bidir_port_oe_out,
   // input-only pins
   input wire logic [3:0] input_only_port_in,
   output logic input_only_pulldown_out,
   // push-pull output pins
   output logic [3:0] pushpull_out_port_a_out,
   output logic [3:0] pushpull_out_port_b_out,
   // open-drain output pins (drive low while oe high)
   output logic [3:0] opendrain_out_port_a_oe_out,
   output logic [3:0] opendrain_out_port_b_oe_out,
   output logic [3:0] opendrain_out_port_c_oe_out,
   output logic [3:0] opendrain_out_port_d_oe_out
);
   // ****************************************
   // pin synchronisers
   // ****************************************
   localparam int NPIN = 24;
   logic [NPIN-1:0] pin_raw;
   logic [NPIN-1:0] sync1_reg;
   logic [NPIN-1:0] sync2_reg;
   logic [NPIN-1:0] sync3_reg;
   logic [NPIN-1:0] pin_level_reg;
   assign pin_raw = {input_only_port_in, fourth_bidir_port_in, nibble_bidir_port_in,
                     third_bidir_port_in, second_bidir_port_in, first_bidir_port_in};
   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
         sync3_reg <= '0;
      end else begin
         sync1_reg <= pin_raw;
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
      end
   end
   // a change counts only once the second and third stages agree
   genvar gi;
   generate
      for (gi = 0; gi < NPIN; gi++) begin : g_filt
         always_ff @(posedge clock_in or negedge reset_n_in) begin
            if (!reset_n_in) begin
               pin_level_reg[gi] <= 1'b0;
            end else if (sync2_reg[gi] == sync3_reg[gi]) begin
               pin_level_reg[gi] <= sync3_reg[gi];
            end
         end
      end
   endgenerate
   logic [3:0] lvl_first;
   logic [3:0] lvl_second;
   logic [3:0] lvl_third;
   logic [3:0] lvl_nibble;
   logic [3:0] lvl_fourth;
   logic [3:0] lvl_input;
   assign {lvl_input, lvl_fourth, lvl_nibble, lvl_third, lvl_second, lvl_first} = pin_level_reg;
   // ****************************************
   // address decode
   // ****************************************
   logic hit_first;
   logic hit_second;
   logic hit_ppa;
   logic hit_input;
   logic hit_oda;
   logic hit_third;
   logic hit_nibble;
   logic hit_ppb;
   logic hit_odb;
   logic hit_odc;
   logic hit_odd;
   logic hit_fourth;
   logic wr_ok;
   always_comb begin
      hit_first = access_in.bank == nbp_pkg::BANK_0 && access_in.addr == nbp_pkg::OFS_PORT_X0;
      hit_second = access_in.bank == nbp_pkg::BANK_0 && access_in.addr == nbp_pkg::OFS_PORT_X1;
      hit_ppa = access_in.bank == nbp_pkg::BANK_0 && access_in.addr == nbp_pkg::OFS_PORT_X2;
      hit_input = access_in.bank == nbp_pkg::BANK_0 && access_in.addr == nbp_pkg::OFS_PORT_X3;
      hit_oda = access_in.bank == nbp_pkg::BANK_1 && access_in.addr == nbp_pkg::OFS_PORT_X0;
      hit_third = access_in.bank == nbp_pkg::BANK_1 && access_in.addr == nbp_pkg::OFS_PORT_X1;
      hit_nibble = access_in.bank == nbp_pkg::BANK_1 && access_in.addr == nbp_pkg::OFS_PORT_X2;
      hit_ppb = access_in.bank == nbp_pkg::BANK_1 && access_in.addr == nbp_pkg::OFS_PORT_X3;
      hit_odb = access_in.bank == nbp_pkg::BANK_2 && access_in.addr == nbp_pkg::OFS_PORT_X0;
      hit_odc = access_in.bank == nbp_pkg::BANK_2 && access_in.addr == nbp_pkg::OFS_PORT_X1;
      hit_odd = access_in.bank == nbp_pkg::BANK_2 && access_in.addr == nbp_pkg::OFS_PORT_X2;
      hit_fourth = access_in.bank == nbp_pkg::BANK_2 && access_in.addr == nbp_pkg::OFS_PORT_2D;
   end
   assign wr_ok = access_in.wr && !halt_in;
   // ****************************************
   // direction select registers
   // ****************************************
   nbp_pkg::nbp_dir_t dir_reg;
   // any reset or clock stop returns pins to input
   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         dir_reg <= '0;
      end else if (ce_reset_in || clock_stop_in) begin
         dir_reg <= '0;
      end else if (dir_we_in && !halt_in) begin
         // per-bit or one nibble-wide direction bit
         dir_reg <= dir_in;
         dir_reg.fourth <= dir_in.fourth & nbp_pkg::MASK_2D;
      end
   end
   assign dir_out = dir_reg;
   logic [3:0] oe_nib;
   assign oe_nib = dir_reg.nibble ? nbp_pkg::NIB_ONES : nbp_pkg::NIB_ZERO;
   // ****************************************
   // bidirectional output latches
   // ****************************************
   logic [3:0] lat_first_reg;
   logic [3:0] lat_second_reg;
   logic [3:0] lat_third_reg;
   logic [3:0] lat_nibble_reg;
   logic [3:0] lat_fourth_reg;
   logic [3:0] rmw_mask;
   // only bits in output mode pick up the pin level
   assign rmw_mask = dir_reg.first & nbp_pkg::MASK_RMW;
   // power-on clears; ce reset and clock stop keep contents
   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         lat_first_reg <= '0;
         lat_second_reg <= '0;
         lat_third_reg <= '0;
         lat_nibble_reg <= '0;
         lat_fourth_reg <= '0;
      end else if (wr_ok) begin
         // writes land in the latch whatever the direction
         if (hit_first) begin
            // rmw on bits 0,1 reloads latch from pin
            // the filtered level lags the pin, so a pin that has just moved is missed
            lat_first_reg <= access_in.rmw ? ((access_in.wdata & ~rmw_mask) | (lvl_first & rmw_mask))
                                           : access_in.wdata;
         end
         if (hit_second) begin
            lat_second_reg <= access_in.wdata;
         end
         if (hit_third) begin
            lat_third_reg <= access_in.wdata;
         end
         if (hit_nibble) begin
            lat_nibble_reg <= access_in.wdata;
         end
         if (hit_fourth) begin
            lat_fourth_reg <= access_in.wdata & nbp_pkg::MASK_2D;
         end
      end
   end
   // ****************************************
   // output-only latches
   // ****************************************
   // no reset: undefined at power-on, kept through ce reset
   logic [3:0] lat_ppa_reg;
   logic [3:0] lat_ppb_reg;
   logic [3:0] lat_oda_reg;
   logic [3:0] lat_odb_reg;
   logic [3:0] lat_odc_reg;
   logic [3:0] lat_odd_reg;
   always_ff @(posedge clock_in) begin
      if (wr_ok) begin
         if (hit_ppa) begin
            lat_ppa_reg <= access_in.wdata;
         end
         if (hit_ppb) begin
            lat_ppb_reg <= access_in.wdata;
         end
         if (hit_oda) begin
            lat_oda_reg <= access_in.wdata;
         end
         // only bit 0 of this port has a pin
         if (hit_odb) begin
            lat_odb_reg <= access_in.wdata & nbp_pkg::MASK_2A;
         end
         if (hit_odc) begin
            lat_odc_reg <= access_in.wdata;
         end
         if (hit_odd) begin
            lat_odd_reg <= access_in.wdata;
         end
      end
   end
   // ****************************************
   // pin drive
   // ****************************************
   // drive latch only in output mode, else float
   assign first_bidir_port_out = lat_first_reg;
   assign first_bidir_port_oe_out = dir_reg.first;
   assign second_bidir_port_out = lat_second_reg;
   assign second_bidir_port_oe_out = dir_reg.second;
   assign third_bidir_port_out = lat_third_reg;
   assign third_bidir_port_oe_out = dir_reg.third;
   assign nibble_bidir_port_out = lat_nibble_reg;
   assign nibble_bidir_port_oe_out = oe_nib;
   assign fourth_bidir_port_out = lat_fourth_reg;
   assign fourth_bidir_port_oe_out = dir_reg.fourth;
   assign pushpull_out_port_a_out = lat_ppa_reg;
   assign pushpull_out_port_b_out = lat_ppb_reg;
   // open-drain pulls low on latch zero
   assign opendrain_out_port_a_oe_out = ~lat_oda_reg;
   assign opendrain_out_port_b_oe_out = ~lat_odb_reg & nbp_pkg::MASK_2A;
   assign opendrain_out_port_c_oe_out = ~lat_odc_reg;
   assign opendrain_out_port_d_oe_out = ~lat_odd_reg;
   // pull-down always on for the input port
   assign input_only_pulldown_out = 1'b1;
   // ****************************************
   // read path
   // ****************************************
   logic [3:0] rd_next;
   logic [3:0] rdata_reg;
   // unmapped reads return zero rather than stale data
   always_comb begin
      rd_next = nbp_pkg::NIB_ZERO;
      // pin in input mode, latch in output, bits 0,1 always pin
      if (hit_first) begin
         rd_next = (lvl_first & (~dir_reg.first | nbp_pkg::MASK_RMW))
                   | (lat_first_reg & dir_reg.first & ~nbp_pkg::MASK_RMW);
      end
      if (hit_second) begin
         rd_next = (lvl_second & ~dir_reg.second) | (lat_second_reg & dir_reg.second);
      end
      if (hit_third) begin
         rd_next = (lvl_third & ~dir_reg.third) | (lat_third_reg & dir_reg.third);
      end
      if (hit_nibble) begin
         rd_next = dir_reg.nibble ? lat_nibble_reg : lvl_nibble;
      end
      if (hit_fourth) begin
         rd_next = ((lvl_fourth & ~dir_reg.fourth) | (lat_fourth_reg & dir_reg.fourth))
                   & nbp_pkg::MASK_2D;
      end
      if (hit_input) begin
         rd_next = lvl_input;
      end
      if (hit_ppa) begin
         rd_next = lat_ppa_reg;
      end
      if (hit_ppb) begin
         rd_next = lat_ppb_reg;
      end
      if (hit_oda) begin
         rd_next = lat_oda_reg;
      end
      if (hit_odb) begin
         rd_next = lat_odb_reg;
      end
      if (hit_odc) begin
         rd_next = lat_odc_reg;
      end
      if (hit_odd) begin
         rd_next = lat_odd_reg;
      end
   end
   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rdata_reg <= '0;
      end else if (access_in.rd) begin
         rdata_reg <= rd_next;
      end
   end
   assign rdata_out = rdata_reg;
   // ****************************************
   // checks
   // ****************************************
   chk_float_input: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (dir_we_in && !halt_in && !ce_reset_in && !clock_stop_in)
      |=> ((first_bidir_port_oe_out & ~$past(dir_in.first)) == nbp_pkg::NIB_ZERO))
      else $error("input pin still driving");
   chk_ce_to_input: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (ce_reset_in || clock_stop_in) |=> (second_bidir_port_oe_out == nbp_pkg::NIB_ZERO))
      else $error("ce reset left a pin driving");
   chk_ce_keeps_lat: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (ce_reset_in && !wr_ok) |=> $stable(lat_second_reg))
      else $error("ce reset changed a latch");
   chk_halt_frozen: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      halt_in |=> ($stable(lat_third_reg) && $stable(lat_ppa_reg)))
      else $error("halt changed a latch");
   chk_input_read: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (access_in.rd && hit_input) |=> (rdata_out == $past(lvl_input)))
      else $error("input port read wrong");
   chk_write_latch: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (wr_ok && hit_third) |=> (lat_third_reg == $past(access_in.wdata)))
      else $error("write missed latch");
   chk_pin_read01: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (access_in.rd && hit_first) |=> (rdata_out[1:0] == $past(lvl_first[1:0])))
      else $error("first port low bits not pin level");
   chk_opendrain: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (wr_ok && hit_oda) |=> (opendrain_out_port_a_oe_out == ~$past(access_in.wdata)))
      else $error("open-drain drive wrong");
   chk_nibble_dir: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (dir_we_in && !halt_in && !ce_reset_in && !clock_stop_in)
      |=> (nibble_bidir_port_oe_out == ($past(dir_in.nibble) ? nbp_pkg::NIB_ONES : nbp_pkg::NIB_ZERO)))
      else $error("nibble port not switched as one");
   chk_dir_load: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (dir_we_in && !halt_in && !ce_reset_in && !clock_stop_in) |=> (dir_out.third == $past(dir_in.third)))
      else $error("direction load missed");
   chk_in_mode_read: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (access_in.rd && hit_first && (dir_reg.first == nbp_pkg::NIB_ZERO)) |=> (rdata_out == $past(lvl_first)))
      else $error("input mode read not pin level");
   chk_drive_latch: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (wr_ok && hit_second) |=> (second_bidir_port_out == $past(access_in.wdata)))
      else $error("pin drive not latch value");
   chk_read_latch: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (access_in.rd && hit_third && (dir_reg.third == nbp_pkg::NIB_ONES)) |=> (rdata_out == $past(lat_third_reg)))
      else $error("output mode read not latch");
   chk_rmw_pin: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (wr_ok && hit_first && access_in.rmw)
      |=> ((lat_first_reg & $past(rmw_mask)) == ($past(lvl_first) & $past(rmw_mask))))
      else $error("rmw did not reload pin level");
   chk_halt_dir: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (halt_in && !ce_reset_in && !clock_stop_in) |=> $stable(dir_reg))
      else $error("halt changed a direction");
   chk_pushpull_out: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (wr_ok && hit_ppb) |=> (pushpull_out_port_b_out == $past(access_in.wdata)))
      else $error("push-pull pin not latch value");
   chk_stop_keeps: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (clock_stop_in && !wr_ok) |=> $stable(lat_odc_reg))
      else $error("clock stop changed an output latch");
   chk_unused_bits: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      ((fourth_bidir_port_oe_out | fourth_bidir_port_out) & ~nbp_pkg::MASK_2D) == nbp_pkg::NIB_ZERO)
      else $error("unimplemented bit reached a pin");
   chk_od_float: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (wr_ok && hit_odc) |=> (opendrain_out_port_c_oe_out == ~$past(access_in.wdata)))
      else $error("open-drain release wrong");
endmodule : nbp_port_bank

// *** bench/nbp_pin_model.sv ***
// Purpose: external circuits on one 4-bit port, resolving pin levels
// Assumes: outside drive is stronger than the port's own driver
// Notes: undriven pins without pull-down toggle every cycle
`timescale 1ns/1ps
module nbp_pin_model (
   // clock
   input wire logic clock_in,
   // port side
   input wire logic [3:0] drive_in,
   input wire logic [3:0] oe_in,
   input wire logic pull_dn_in,
   // outside circuit
   input wire logic [3:0] ext_val_in,
   input wire logic [3:0] ext_en_in,
   // resolved level
   output logic [3:0] pin_out
);
   logic [3:0] float_reg = 4'h5;
   // a floating line must never look like a stable level
   always @(posedge clock_in) begin
      float_reg <= ~float_reg;
   end
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         if (ext_en_in[i]) begin
            pin_out[i] = ext_val_in[i];
         end else if (oe_in[i]) begin
            pin_out[i] = drive_in[i];
         end else begin
            pin_out[i] = pull_dn_in ? 1'b0 : float_reg[i];
         end
      end
   end
endmodule : nbp_pin_model

// *** bench/nbp_port_bank_test.sv ***
// Purpose: self-checking bench for the nibble port bank
// Assumes: inputs driven at falling edge, reads one cycle after request
// Notes: pin changes need about five cycles to reach reads
`timescale 1ns/1ps
module nbp_port_bank_test;
   logic clk = 1'b0, rst_n = 1'b0, ce = 1'b0, cstop = 1'b0, halt = 1'b0, dwe = 1'b0;
   nbp_pkg::nbp_access_t acc = '0;
   nbp_pkg::nbp_dir_t dir = '0, dir_o;
   logic [3:0] rdata, ppa, ppb, oda, odb, odc, odd, wexp;
   logic [3:0] drv [0:5], oe [0:5], pin [0:5], ev [0:5], ee [0:5];
   logic pdn;
   int n_fail = 0, compares = 0, cycles = 0;
   initial forever #20 clk = ~clk;
   initial for (int i = 0; i < 6; i++) begin ev[i] = 4'ha; ee[i] = 4'hf; end
   assign drv[5] = 4'h0;
   assign oe[5] = 4'h0;
   nbp_port_bank i_nbp_port_bank (.clock_in(clk), .reset_n_in(rst_n), .ce_reset_in(ce), .clock_stop_in(cstop),
      .halt_in(halt), .access_in(acc), .rdata_out(rdata), .dir_we_in(dwe), .dir_in(dir), .dir_out(dir_o),
      .first_bidir_port_in(pin[0]), .first_bidir_port_out(drv[0]), .first_bidir_port_oe_out(oe[0]),
      .second_bidir_port_in(pin[1]), .second_bidir_port_out(drv[1]), .second_bidir_port_oe_out(oe[1]),
      .third_bidir_port_in(pin[2]), .third_bidir_port_out(drv[2]), .third_bidir_port_oe_out(oe[2]),
      .nibble_bidir_port_in(pin[3]), .nibble_bidir_port_out(drv[3]), .nibble_bidir_port_oe_out(oe[3]),
      .fourth_bidir_port_in(pin[4]), .fourth_bidir_port_out(drv[4]), .fourth_bidir_port_oe_out(oe[4]),
      .input_only_port_in(pin[5]), .input_only_pulldown_out(pdn), .pushpull_out_port_a_out(ppa),
      .pushpull_out_port_b_out(ppb), .opendrain_out_port_a_oe_out(oda), .opendrain_out_port_b_oe_out(odb),
      .opendrain_out_port_c_oe_out(odc), .opendrain_out_port_d_oe_out(odd));
   for (genvar g = 0; g < 6; g++) begin : g_pins
      nbp_pin_model i_nbp_pin_model (.clock_in(clk), .drive_in(drv[g]), .oe_in(oe[g]),
         .pull_dn_in(g == 5 ? pdn : 1'b0), .ext_val_in(ev[g]), .ext_en_in(ee[g]), .pin_out(pin[g]));
   end
   // ****************************************
   // tasks
   // ****************************************
   task automatic check(input string name, input logic [16:0] seen, input logic [16:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic wr(input logic [1:0] b, input logic [6:0] a, input logic [3:0] d, input logic m);
      @(negedge clk);
      acc.bank = b; acc.addr = a; acc.wdata = d; acc.wr = 1'b1; acc.rmw = m;
      @(negedge clk);
      acc.wr = 1'b0; acc.rmw = 1'b0;
   endtask : wr
   task automatic rd(input logic [1:0] b, input logic [6:0] a, input logic [3:0] exp, input string name);
      @(negedge clk);
      acc.bank = b; acc.addr = a; acc.rd = 1'b1;
      @(negedge clk);
      acc.rd = 1'b0;
      check(name, 17'(rdata), 17'(exp));
   endtask : rd
   task automatic load_dir(input nbp_pkg::nbp_dir_t d);
      @(negedge clk);
      dir = d; dwe = 1'b1;
      @(negedge clk);
      dwe = 1'b0;
   endtask : load_dir
   task automatic report_and_stop;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : report_and_stop
   // run must finish in well under this many cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles >= 3000) begin
         n_fail++;
         report_and_stop();
      end
   end
   // ****************************************
   // tests
   // ****************************************
   logic [1:0] bk [0:10] = '{0, 0, 1, 1, 2, 0, 1, 1, 2, 2, 2};
   logic [6:0] ad [0:10] = '{7'h70, 7'h71, 7'h71, 7'h72, 7'h6f, 7'h72, 7'h73, 7'h70, 7'h70, 7'h71, 7'h72};
   logic [3:0] mk [0:10] = '{4'hf, 4'hf, 4'hf, 4'hf, 4'h7, 4'hf, 4'hf, 4'hf, 4'h1, 4'hf, 4'hf};
   logic [3:0] po [0:10];
   always_comb po = '{drv[0], drv[1], drv[2], drv[3], drv[4], ppa, ppb, oda, odb, odc, odd};
   initial begin
      repeat (20) @(negedge clk);
      rst_n = 1'b1;
      repeat (3) @(negedge clk);
      check("dir_out", 17'(dir_o), 17'h0);
      check("first_latch", 17'(drv[0]), 17'h0);
      check("nibble_oe", 17'(oe[3]), 17'h0);
      rd(0, 7'h70, 4'ha, "first_in");
      rd(0, 7'h73, 4'ha, "input_only");
      check("pulldown", 17'(pdn), 17'h1);
      wr(0, 7'h70, 4'h5, 1'b0);
      check("first_latch_in", 17'(drv[0]), 17'h5);
      check("first_oe_in", 17'(oe[0]), 17'h0);
      $display("test input_mode done");
      for (int i = 0; i < 6; i++) ee[i] = 4'h0;
      ee[5] = 4'h3; ev[5] = 4'h3;
      load_dir('{first: 4'h0, second: 4'h6, third: 4'h0, nibble: 1'b1, fourth: 4'h0});
      check("second_oe", 17'(oe[1]), 17'h6);
      check("nibble_oe", 17'(oe[3]), 17'hf);
      load_dir('{first: 4'hf, second: 4'hf, third: 4'hf, nibble: 1'b1, fourth: 4'h7});
      check("dir_out", 17'(dir_o), 17'h1ffff & {4'hf, 4'hf, 4'hf, 1'b1, 4'h7});
      check("third_oe", 17'(oe[2]), 17'hf);
      check("fourth_oe", 17'(oe[4]), 17'h7);
      for (int i = 0; i < 11; i++) wr(bk[i], ad[i], 4'hc ^ 4'(i), 1'b0);
      wr(0, 7'h73, 4'hf, 1'b0);
      repeat (5) @(negedge clk);
      for (int i = 0; i < 11; i++) begin
         wexp = (4'hc ^ 4'(i)) & mk[i];
         check($sformatf("pin_out %0d", i), 17'(po[i]), 17'(i >= 7 ? ~wexp & mk[i] : wexp));
         rd(bk[i], ad[i], wexp, $sformatf("readback %0d", i));
      end
      rd(0, 7'h73, 4'h3, "input_only_wr");
      check("pulldown_pins", 17'(pin[5]), 17'h3);
      $display("test output_mode done");
      wr(0, 7'h70, 4'h3, 1'b0);
      ee[0] = 4'h1; ev[0] = 4'h0;
      repeat (6) @(negedge clk);
      rd(0, 7'h70, 4'h2, "first_pin_read");
      wr(0, 7'h70, 4'hf, 1'b1);
      check("first_rmw", 17'(drv[0]), 17'he);
      ee[0] = 4'h0;
      $display("test pin_read done");
      halt = 1'b1;
      wr(0, 7'h70, 4'h0, 1'b0);
      wr(0, 7'h72, 4'h0, 1'b0);
      load_dir('0);
      check("halt_latch", 17'(drv[0]), 17'he);
      check("halt_pp", 17'(ppa), 17'(4'h9));
      check("halt_dir", 17'(oe[0]), 17'hf);
      halt = 1'b0;
      $display("test halt done");
      @(negedge clk) ce = 1'b1;
      @(negedge clk) ce = 1'b0;
      check("ce_dir", 17'(dir_o), 17'h0);
      check("ce_latch", 17'(drv[0]), 17'he);
      check("ce_pp", 17'(ppa), 17'(4'h9));
      load_dir('{first: 4'hf, second: 4'hf, third: 4'hf, nibble: 1'b1, fourth: 4'h7});
      @(negedge clk) cstop = 1'b1;
      @(negedge clk) cstop = 1'b0;
      check("stop_oe", 17'(oe[3]), 17'h0);
      check("stop_latch", 17'(drv[2]), 17'(4'he));
      check("stop_od", 17'(odc), 17'h00a);
      $display("test ce_stop done");
      @(negedge clk) rst_n = 1'b0;
      @(negedge clk) rst_n = 1'b1;
      check("por_latch", 17'(drv[2]), 17'h0);
      check("por_dir", 17'(dir_o), 17'h0);
      $display("test power_on done");
      report_and_stop();
   end
endmodule : nbp_port_bank_test
